// ### src/rcim_defs.vh
// Purpose: Offsets, field positions and reset values of the receive-cell interrupt block
// Assumes: 8-bit microprocessor register port, byte offsets as printed
// Notes: Definitions only
`ifndef RCIM_DEFS_VH
`define RCIM_DEFS_VH

`define RCIM_ADDR_W 8
`define RCIM_OFF_RX_CELL_IRQ_MASK 8'h39
`define RCIM_OFF_TOP_IRQ_SUMMARY 8'h3c
`define RCIM_OFF_RX_CELL_EVENT 8'h41
`define RCIM_MASK_RESET 8'hef
`define RCIM_MASK_RSVD_BIT 4
`define RCIM_BIT_SECTION 7
`define RCIM_BIT_LINE 6
`define RCIM_BIT_PATH 5
`define RCIM_BIT_TICK 4
`define RCIM_BIT_RX_CELL 1
`define RCIM_SUMEN_RX_CELL_BIT 1
`define RCIM_GEN_PIN_EN_BIT 6

`endif

// ### src/rcim_event_latch.v
// Purpose: Eight single-event indication latches with read-to-clear
// Assumes: Sources are on ref_clk already
// Notes: A new event in the clear cycle survives the clear
`timescale 1ns/10ps

module rcim_event_latch (
    ref_clk,
    reset_n,
    status_in,
    source_enable,
    read_clear,
    event_reg
);
    input wire ref_clk;
    input wire reset_n;
    input wire [7:0] status_in;
    input wire [7:0] source_enable;
    input wire read_clear;
    output reg [7:0] event_reg;

    reg [7:0] status_prev_reg;
    wire [7:0] rise;

    assign rise = status_in & ~status_prev_reg & source_enable;

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            status_prev_reg <= 8'h00;
            event_reg <= 8'h00;
        end else begin
            status_prev_reg <= status_in;
            // Set wins over the read clear [RL17]
            event_reg <= (read_clear ? 8'h00 : event_reg) | rise;
        end
    end
endmodule // rcim_event_latch

// ### src/rcim_top.v
// Purpose: Receive-cell interrupt mask, top summary register and interrupt pin
// Assumes: Registers reached by a single-cycle read/write strobe port on ref_clk
// Notes: Section, line and path events come in as pending levels
//
// Functional notes
// RL1: Pin needs summary enable and global pin enable
// RL2: Mask bit 7 gates delineation loss
// RL3: Mask bit 6 gates header error detected
// RL4: Mask bit 5 gates header error corrected
// RL5: Reserved mask bit 4, summary bit 3 zero
// RL6: Mask bit 3 gates cell received
// RL7: Mask bit 2 gates idle cell received
// RL8: Mask bit 1 gates mismatched cell
// RL9: Mask bit 0 gates nonzero flow field
// RL10: Summary bit 7 shows section events pending
// RL11: Summary bit 6 shows line events pending
// RL12: Summary bit 5 shows path events pending
// RL13: Each second pulse rising edge sets bit 4
// RL14: Summary read clears the second tick flag
// RL15: Summary bit 1 shows receive-cell events pending
// RL16: Other summary bits clear only at source
// RL17: Single events latch on rise, read clears
// RL18: Pin low while any enabled event pends
`timescale 1ns/10ps
`include "rcim_defs.vh"

module rcim_top (
    ref_clk,
    reset_n,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    section_pending,
    line_pending,
    path_pending,
    rx_cell_status,
    rx_cell_source_enable,
    rx_cell_summary_enable,
    global_irq_pin_enable,
    second_pulse_input,
    irq_out_n
);
    input wire ref_clk;
    input wire reset_n;
    input wire [7:0] reg_addr;
    input wire reg_wr;
    input wire reg_rd;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    input wire section_pending;
    input wire line_pending;
    input wire path_pending;
    input wire [7:0] rx_cell_status;
    input wire [7:0] rx_cell_source_enable;
    input wire rx_cell_summary_enable;
    input wire global_irq_pin_enable;
    input wire second_pulse_input;
    output reg irq_out_n;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode
    reg [7:0] rx_cell_irq_mask_reg;
    reg second_tick_flag_reg;
    reg [2:0] pulse_sync_reg;
    wire [7:0] rx_cell_event;
    wire [7:0] summary_value;
    wire wr_mask;
    wire rd_summary;
    wire rd_cell;
    wire tick_rise;
    wire cell_irq;

    assign wr_mask = reg_wr && (reg_addr == `RCIM_OFF_RX_CELL_IRQ_MASK);
    assign rd_summary = reg_rd && (reg_addr == `RCIM_OFF_TOP_IRQ_SUMMARY);
    assign rd_cell = reg_rd && (reg_addr == `RCIM_OFF_RX_CELL_EVENT);

    ////////////////////////////////////////////////////////////////////////////
    // Receive-cell indications, bit order matches the mask layout
    rcim_event_latch u_cell_events (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .status_in(rx_cell_status),
        .source_enable(rx_cell_source_enable),
        .read_clear(rd_cell),
        .event_reg(rx_cell_event)
    ); // [RL17]

    ////////////////////////////////////////////////////////////////////////////
    // Mask register; reserved bit forced low so stray writes cannot set it
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_cell_irq_mask_reg <= `RCIM_MASK_RESET;
        end else if (wr_mask) begin
            rx_cell_irq_mask_reg <= reg_wdata & ~(8'h01 << `RCIM_MASK_RSVD_BIT); // [RL5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-second pulse: two-flop sync, then edge detect on later stages
    assign tick_rise = pulse_sync_reg[1] & ~pulse_sync_reg[2];

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pulse_sync_reg <= 3'h0;
            second_tick_flag_reg <= 1'b0;
        end else begin
            pulse_sync_reg <= {pulse_sync_reg[1:0], second_pulse_input};
            // Edge in the read cycle is kept for the next read [RL13] [RL14]
            second_tick_flag_reg <= tick_rise | (second_tick_flag_reg & ~rd_summary);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary value: bits other than the tick flag follow their sources, not cleared by this read [RL16]
    assign summary_value = {section_pending,             // [RL10]
                            line_pending,                // [RL11]
                            path_pending,                // [RL12]
                            second_tick_flag_reg,        // [RL13]
                            1'b0,                        // [RL5]
                            1'b0,
                            |rx_cell_event,              // [RL15]
                            1'b0};

    // Read data registered; answer one cycle after the strobe
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RCIM_OFF_RX_CELL_IRQ_MASK: reg_rdata <= rx_cell_irq_mask_reg;
                `RCIM_OFF_TOP_IRQ_SUMMARY: reg_rdata <= summary_value;
                `RCIM_OFF_RX_CELL_EVENT: reg_rdata <= rx_cell_event;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin; bit 4 of the mask is always zero so it gates nothing
    // [RL2] [RL3] [RL4] [RL6] [RL7] [RL8] [RL9]
    assign cell_irq = |(rx_cell_event & rx_cell_irq_mask_reg);

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~(cell_irq & rx_cell_summary_enable & global_irq_pin_enable); // [RL1] [RL18]
        end
    end
endmodule // rcim_top

// ### tb/rcim_host_model.sv
// Purpose: Host processor model for the register strobes
// Assumes: Called at or before a falling edge
// Notes: Leaves one idle cycle before each access
`timescale 1ns/10ps
module rcim_host (
    input wire ref_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    // Strobe spans one rising edge; read data stands after it
    task acc(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, addr, data};
        @(negedge ref_clk);
        {reg_wr, reg_rd} = 2'b00;
    endtask
endmodule // rcim_host

// ### tb/rcim_properties.sv
// Purpose: Port checks for rcim_top
// Assumes: One-cycle register strobes
// Notes: Bound to every rcim_top
`timescale 1ns/10ps
module rcim_chk (
    input logic ref_clk, reset_n, reg_wr, reg_rd, irq_out_n, second_pulse_input,
    input logic section_pending, line_pending, path_pending,
    input logic rx_cell_summary_enable, global_irq_pin_enable,
    input logic [7:0] reg_addr, reg_wdata, reg_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic sum_rd, m_rd, m_wr, en;
    assign sum_rd = reg_rd && reg_addr == 8'h3c;
    assign m_rd = reg_rd && reg_addr == 8'h39;
    assign m_wr = reg_wr && reg_addr == 8'h39;
    assign en = rx_cell_summary_enable && global_irq_pin_enable;
    //////////////////////////////
    sequence s_quiet; !second_pulse_input [*4]; endsequence
    sequence s_twice; s_quiet ##0 sum_rd ##1 s_quiet ##0 sum_rd; endsequence
    property p_pin_off; !en |=> irq_out_n; endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin off");
    property p_none; m_wr && reg_wdata == 8'h00 |=> ##1 irq_out_n; endproperty
    a_none: assert property (p_none) else $error("mask none");
    property p_sum; sum_rd |=> {reg_rdata[7:5], reg_rdata[3:2], reg_rdata[0]} ==
        {$past(section_pending), $past(line_pending), $past(path_pending), 3'b000};
    endproperty
    a_sum: assert property (p_sum) else $error("summary");
    property p_rsvd; m_rd |=> !reg_rdata[4]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved");
    property p_rw; m_wr ##2 m_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hef); endproperty
    a_rw: assert property (p_rw) else $error("mask rw");
    property p_tick_set;
        $rose(second_pulse_input) ##1 !sum_rd [*4] ##1 sum_rd |=> reg_rdata[4];
    endproperty
    a_tick_set: assert property (p_tick_set) else $error("tick set");
    property p_tick_clr; s_twice |=> !reg_rdata[4]; endproperty
    a_tick_clr: assert property (p_tick_clr) else $error("tick clear");
    property p_evt; sum_rd ##2 reg_rd && reg_addr == 8'h41 && reg_rdata[1] |=> reg_rdata != 0;
    endproperty
    a_evt: assert property (p_evt) else $error("event");
endmodule // rcim_chk
bind rcim_top rcim_chk chk_u (.*);

// ### tb/rx_cell_irq_mask_and_summary_tb_top.sv
// Purpose: Bench for rcim_top
// Assumes: Host model does one access per call
// Notes: Rows are {mask, status, enables, pin}
`timescale 1ns/10ps
module rx_cell_irq_mask_and_summary_tb_top;
    logic ref_clk = 0, reset_n = 0, reg_wr, reg_rd, irq_out_n, second_pulse_input = 0;
    logic section_pending = 0, line_pending = 0, path_pending = 0;
    logic rx_cell_summary_enable = 0, global_irq_pin_enable = 0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_cell_status = 0, rx_cell_source_enable = 8'hff;
    logic [23:0] rows [10] = '{24'hef8030, 24'h6f8031, 24'h404030, 24'h202030,
        24'h080830, 24'h040430, 24'h020230, 24'h010130,
        24'hef2021, 24'h00ef31};
    int error_cnt = 0, tests_run = 0;
    rcim_top dut_u (.*);
    rcim_host host_u (.*);
    //////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rd(input logic [7:0] a);
        host_u.acc(1'b0, a, 8'h00);
    endtask
    task conclude;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #5 ref_clk = ~ref_clk;
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        conclude;
    end
    initial begin
        repeat (12) @(negedge ref_clk);
        reset_n = 1;
        foreach (rows[k]) begin
            host_u.acc(1'b1, 8'h39, rows[k][23:16]);
            {rx_cell_summary_enable, global_irq_pin_enable} = rows[k][5:4];
            rx_cell_status = rows[k][15:8];
            repeat (4) @(negedge ref_clk);
            chk(irq_out_n, rows[k][0]);
            rd(8'h3c);
            chk(reg_rdata[1], 1'b1);
            rd(8'h41);
            chk(reg_rdata, rows[k][15:8]);
            rd(8'h3c);
            chk(reg_rdata[1], 1'b0);
            chk(irq_out_n, 1'b1);
            rx_cell_status = 8'h00;
        end
        reset_n = 0;
        repeat (2) @(negedge ref_clk);
        chk(reg_rdata, 8'h00);
        reset_n = 1;
        rd(8'h39);
        chk(reg_rdata, 8'hef);
        host_u.acc(1'b1, 8'h39, 8'hff);
        rd(8'h39);
        chk(reg_rdata, 8'hef);
        {section_pending, line_pending, path_pending} = 3'b101;
        rd(8'h3c);
        chk(reg_rdata & 8'hef, 8'ha0);
        {section_pending, line_pending, path_pending} = 3'b010;
        rd(8'h3c);
        chk(reg_rdata & 8'hef, 8'h40);
        second_pulse_input = 1;
        repeat (2) @(negedge ref_clk);
        second_pulse_input = 0;
        repeat (2) @(negedge ref_clk);
        rd(8'h3c);
        chk(reg_rdata[4], 1'b1);
        repeat (2) @(negedge ref_clk);
        rd(8'h3c);
        chk(reg_rdata[4], 1'b0);
        // A disabled source must not latch its rising status
        rx_cell_source_enable = 8'h7f;
        rx_cell_status = 8'h80;
        repeat (3) @(negedge ref_clk);
        chk(irq_out_n, 1'b1);
        rd(8'h41);
        chk(reg_rdata, 8'h00);
        conclude;
    end
endmodule // rx_cell_irq_mask_and_summary_tb_top
